// [usbis_status.sv]
/*
  Interrupt status word zero of a dual-role USB controller, with its mask,
  a control register and the level interrupt output.
  Assumes bus-power and D+ pins are asynchronous; all engine inputs are on clk.
*/
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module usbis_status #(
  parameter int FRAME_CYCLES = usbis_pkg::USBIS_FRAME_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // USB pins
  input wire logic vbus_pin,
  input wire logic dp_pin,
  // Protocol engine
  input wire logic sof_rx,
  input wire logic setup_rx,
  input wire logic [2:0] dev_state_in,
  input wire logic [2:0] stage_in,
  // Per-pipe status and enables
  input wire logic [9:0] pipe_ready_status,
  input wire logic [9:0] pipe_ready_enable,
  input wire logic [9:0] pipe_not_ready_status,
  input wire logic [9:0] pipe_not_ready_enable,
  input wire logic [9:0] pipe_empty_status,
  input wire logic [9:0] pipe_empty_enable,
  // Interrupt
  output logic irq
);
  import usbis_pkg::*;

  // Address match, used by every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  usbis_edge_if vb_if ();
  usbis_edge_if dp_if ();

  // Pin synchronisers
  // Both pins are asynchronous; their edges come out two clocks after the pin
  usbis_pin_sync u_vbus_sync (
    .clk(clk),
    .rst(rst),
    .pin(vbus_pin),
    .edge_o(vb_if.src)
  );

  usbis_pin_sync u_dp_sync (
    .clk(clk),
    .rst(rst),
    .pin(dp_pin),
    .edge_o(dp_if.src)
  );

  logic bus_power_change_flag_r;
  logic resume_flag_r;
  logic frame_update_flag_r;
  logic device_state_change_flag_r;
  logic stage_change_flag_r;
  logic valid_r;
  logic [2:0] device_state_field_r;
  logic [2:0] control_stage_field_r;
  logic [2:0] summ_r;
  logic [15:0] mask_r;
  logic [3:0] ctrl_r;
  logic [15:0] rdata_r;
  logic [USBIS_FCNT_W-1:0] fcnt_r;
  logic [USBIS_FCNT_W-1:0] fcnt_nxt;
  logic peri_q_r;
  usbis_fstate_t fstate_r;
  usbis_fstate_t fstate_nxt;

  // Register decode
  // Unmapped addresses decode to nothing: writes are lost, reads give zero
  wire wr_status = wr & hit(addr, USBIS_STATUS_OFF);
  wire wr_mask = wr & hit(addr, USBIS_MASK_OFF);
  wire wr_ctrl = wr & hit(addr, USBIS_CTRL_OFF);
  wire rd_status = rd & hit(addr, USBIS_STATUS_OFF);
  wire rd_mask = rd & hit(addr, USBIS_MASK_OFF);
  wire rd_ctrl = rd & hit(addr, USBIS_CTRL_OFF);

  // Control bits; a role change sends the frame timer to idle, so a count
  // left from the old role can raise a frame update in the new one only in the flip cycle
  wire peri = ctrl_r[USBIS_CTRL_PERI_BIT];
  wire port_act = ctrl_r[USBIS_CTRL_ACT0_BIT] | ctrl_r[USBIS_CTRL_ACT1_BIT];
  wire sce = ctrl_r[USBIS_CTRL_SYSTEM_CLOCK_ENABLE_BIT];
  wire role_flip = peri != peri_q_r;

  // Per-bit clear strobes: only a written zero clears
  wire [15:0] clr = {16{wr_status}} & ~wdata & USBIS_CLEARABLE;

  // Event detection; bus-power and resume edges ignore the clock enable,
  // as they must be caught while software has stopped the system clock
  wire vb_evt = vb_if.rise | vb_if.fall;
  wire suspended = device_state_field_r[2];
  wire resume_flag_evt = peri & suspended & dp_if.fall;
  wire device_state_change_flag_evt = peri & sce & (dev_state_in != device_state_field_r);
  wire stage_change_flag_evt = peri & sce & (stage_in != control_stage_field_r);
  wire setup_evt = peri & sce & setup_rx;

  // Frame timer decode
  wire fcnt_end = fcnt_r == USBIS_FCNT_W'(FRAME_CYCLES - 1);
  wire frun = fstate_r == USBIS_FS_RUN;
  wire host_tick = ~peri & frun & port_act & fcnt_end;
  wire peri_sof = peri & sce & sof_rx;
  wire peri_interp = peri & frun & fcnt_end & ~sof_rx;
  wire frame_tick = host_tick | peri_sof | peri_interp;

  // Frame timer next state
  // Host role runs while a port is active; peripheral role waits for a frame start
  always_comb begin
    fstate_nxt = fstate_r;
    case (fstate_r)
      USBIS_FS_IDLE: begin
        if (sce & ~role_flip & (peri ? sof_rx : port_act)) begin
          fstate_nxt = USBIS_FS_RUN;
        end
      end
      USBIS_FS_RUN: begin
        if (~sce | role_flip | (~peri & ~port_act)) begin
          fstate_nxt = USBIS_FS_IDLE;
        end
      end
      default: begin
        fstate_nxt = USBIS_FS_IDLE;
      end
    endcase
  end

  // Frame counter restarts on a received frame start or at wrap
  // FRAME_CYCLES must fit in the counter width
  always_comb begin
    fcnt_nxt = fcnt_r + USBIS_FCNT_W'(1);
    if (fstate_nxt != USBIS_FS_RUN || peri_sof || fcnt_end) begin
      fcnt_nxt = '0;
    end
  end

  // Frame timer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      fstate_r <= USBIS_FS_IDLE;
      fcnt_r <= '0;
      peri_q_r <= 1'b0;
    end else begin
      fstate_r <= fstate_nxt;
      fcnt_r <= fcnt_nxt;
      peri_q_r <= peri;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  // Keeping the event means a clear racing a new edge never loses an
  // interrupt; software simply sees the flag again
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_power_change_flag_r <= 1'b0;
      resume_flag_r <= 1'b0;
      frame_update_flag_r <= 1'b0;
      device_state_change_flag_r <= 1'b0;
      stage_change_flag_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      bus_power_change_flag_r <= vb_evt | (bus_power_change_flag_r & ~clr[USBIS_BUS_POWER_CHANGE_FLAG_BIT]);
      resume_flag_r <= resume_flag_evt | (resume_flag_r & ~clr[USBIS_RESUME_FLAG_BIT]);
      frame_update_flag_r <= frame_tick | (frame_update_flag_r & ~clr[USBIS_FRAME_UPDATE_FLAG_BIT]);
      device_state_change_flag_r <= device_state_change_flag_evt | (device_state_change_flag_r & ~clr[USBIS_DEVICE_STATE_CHANGE_FLAG_BIT]);
      stage_change_flag_r <= stage_change_flag_evt | (stage_change_flag_r & ~clr[USBIS_STAGE_CHANGE_FLAG_BIT]);
      valid_r <= setup_evt | (valid_r & ~clr[USBIS_VALID_BIT]);
    end
  end

  // State and stage fields follow the engine in peripheral role only
  // In host role they hold their last value, which reads as undefined there
  always_ff @(posedge clk) begin
    if (rst) begin
      device_state_field_r <= USBIS_FIELD_RESET;
      control_stage_field_r <= USBIS_FIELD_RESET;
    end else begin
      if (device_state_change_flag_evt) begin
        device_state_field_r <= dev_state_in;
      end
      if (stage_change_flag_evt) begin
        control_stage_field_r <= stage_in;
      end
    end
  end

  // Buffer summaries, one per kind
  // Each kind is the OR of its per-pipe status bits gated by their enables
  wire [9:0] pipe_stat [USBIS_SUM_KINDS];
  wire [9:0] pipe_en [USBIS_SUM_KINDS];
  assign pipe_stat[USBIS_SUM_READY] = pipe_ready_status;
  assign pipe_stat[USBIS_SUM_BUFFER_NOT_READY_SUMMARY] = pipe_not_ready_status;
  assign pipe_stat[USBIS_SUM_EMPTY] = pipe_empty_status;
  assign pipe_en[USBIS_SUM_READY] = pipe_ready_enable;
  assign pipe_en[USBIS_SUM_BUFFER_NOT_READY_SUMMARY] = pipe_not_ready_enable;
  assign pipe_en[USBIS_SUM_EMPTY] = pipe_empty_enable;

  // Summary flags ignore software writes entirely
  wire [2:0] summ_nxt;
  for (genvar k = 0; k < USBIS_SUM_KINDS; k++) begin : g_summ
    assign summ_nxt[k] = |(pipe_stat[k] & pipe_en[k]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      summ_r <= 3'h0;
    end else begin
      summ_r <= summ_nxt;
    end
  end

  // Assembled status word
  wire [15:0] status_word = {bus_power_change_flag_r, resume_flag_r, frame_update_flag_r, device_state_change_flag_r, stage_change_flag_r, summ_r,
                             vb_if.level, device_state_field_r, valid_r, control_stage_field_r};

  // Mask and control registers
  // Unused mask bits are stored as zero so irq sees only event and summary bits
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= USBIS_MASK_RESET;
      ctrl_r <= USBIS_CTRL_RESET;
    end else begin
      if (wr_mask) begin
        mask_r <= wdata & USBIS_IRQ_SRC;
      end
      if (wr_ctrl) begin
        ctrl_r <= wdata[3:0];
      end
    end
  end

  // Read data for one cycle after the strobe, zero otherwise
  // Reads have no side effect, so polling the level bit is harmless
  wire [15:0] rd_mux = rd_status ? status_word :
                       rd_mask ? mask_r :
                       rd_ctrl ? {12'h000, ctrl_r} : 16'h0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd_mux;
    end
  end

  // Outputs
  assign rdata = rdata_r;
  assign irq = |(status_word & mask_r & USBIS_IRQ_SRC);

  // Cycles since the last frame update while the peripheral timer runs;
  // a missing update shows as this count reaching a full frame
  logic [USBIS_FCNT_W-1:0] gap_r;
  wire gap_run = peri & frun & ~frame_tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      gap_r <= '0;
    end else if (gap_run) begin
      gap_r <= gap_r + USBIS_FCNT_W'(1);
    end else begin
      gap_r <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_vbus_edge_flag: assert property ((vb_if.rise || vb_if.fall) |=> bus_power_change_flag_r)
    else $error("bus-power edge did not set its flag");
  a_level_bit: assert property (vb_if.rise |=> rdata_r[USBIS_LEVEL_BIT] || !$past(rd_status))
    else $error("level bit does not show high pin");
  a_clear_keeps_one: assert property (wr_status && wdata[USBIS_BUS_POWER_CHANGE_FLAG_BIT] && bus_power_change_flag_r |=> bus_power_change_flag_r)
    else $error("flag written with one was cleared");
  a_clear_by_zero: assert property (wr_status && !wdata[USBIS_FRAME_UPDATE_FLAG_BIT] && !frame_tick |=> !frame_update_flag_r)
    else $error("flag written with zero stayed set");
  a_summary_ignores_write: assert property (wr_status && !wdata[USBIS_SUM_LSB+2] && summ_r[USBIS_SUM_EMPTY]
    && (pipe_empty_status & pipe_empty_enable) != 10'h000 |=> summ_r[USBIS_SUM_EMPTY])
    else $error("summary flag cleared by a write");
  a_summary_drops: assert property ((pipe_ready_status & pipe_ready_enable) == 10'h000
    |=> !summ_r[USBIS_SUM_READY])
    else $error("summary flag stuck with no pipe pending");
  a_host_holds_peri: assert property (!peri && !wr_status |=> $stable({resume_flag_r, device_state_change_flag_r, stage_change_flag_r}))
    else $error("peripheral-only flag moved in host role");
  a_state_tracks: assert property (device_state_change_flag_evt |=> device_state_change_flag_r && device_state_field_r == $past(dev_state_in))
    else $error("device state change not captured");
  a_stage_tracks: assert property (stage_change_flag_evt |=> stage_change_flag_r && control_stage_field_r == $past(stage_in))
    else $error("stage change not captured");
  a_resume_set: assert property (peri && device_state_field_r[2] && dp_if.fall |=> resume_flag_r)
    else $error("resume edge while suspended missed");
  a_setup_set: assert property (setup_evt |=> valid_r)
    else $error("setup packet not flagged");
  a_host_frame_gate: assert property (!peri && !port_act |-> !frame_tick)
    else $error("host frame update with no active port");
  a_frame_interp: assert property (gap_r < USBIS_FCNT_W'(FRAME_CYCLES))
    else $error("interpolated frame update missing");
  a_reset_clear: assert property ($fell(rst) |-> {status_word[15:8], status_word[6:0]} == 15'h0000)
    else $error("reset left a flag or field set");
  a_summary_rises: assert property ((pipe_not_ready_status & pipe_not_ready_enable) != 10'h000
    |=> summ_r[USBIS_SUM_BUFFER_NOT_READY_SUMMARY])
    else $error("summary flag missed a pending pipe");
  a_rdata_idle: assert property (!rd |=> rdata_r == 16'h0000)
    else $error("read data shown without a read");
  a_level_live: assert property (rd_status |=> rdata_r[USBIS_LEVEL_BIT] == $past(vb_if.level))
    else $error("level bit differs from the pin");

  c_vbus_rise: cover property (vb_if.rise ##1 bus_power_change_flag_r);
  c_interp_tick: cover property (peri_interp);
  c_resume: cover property (resume_flag_evt);
  c_clear_setup: cover property (valid_r && wr_status && !wdata[USBIS_VALID_BIT]);
  c_host_tick: cover property (host_tick);

endmodule : usbis_status

// [usbis_pkg.sv]
/*
  Constants shared by the interrupt status word zero block: register offsets,
  field positions, control bits, reset values and frame timing.
  Assumes a 10 MHz system clock and an 8-bit byte address on the register port.
*/
package usbis_pkg;

  // Register byte offsets
  localparam logic [7:0] USBIS_STATUS_OFF = 8'h40;
  localparam logic [7:0] USBIS_MASK_OFF = 8'h44;
  localparam logic [7:0] USBIS_CTRL_OFF = 8'h48;

  // Status word field positions
  localparam int USBIS_BUS_POWER_CHANGE_FLAG_BIT = 15;
  localparam int USBIS_RESUME_FLAG_BIT = 14;
  localparam int USBIS_FRAME_UPDATE_FLAG_BIT = 13;
  localparam int USBIS_DEVICE_STATE_CHANGE_FLAG_BIT = 12;
  localparam int USBIS_STAGE_CHANGE_FLAG_BIT = 11;
  localparam int USBIS_SUM_LSB = 8;
  localparam int USBIS_LEVEL_BIT = 7;
  localparam int USBIS_DEVICE_STATE_FIELD_LSB = 4;
  localparam int USBIS_VALID_BIT = 3;
  localparam int USBIS_CONTROL_STAGE_FIELD_LSB = 0;

  // Summary flag index within the three-bit group
  localparam int USBIS_SUM_READY = 0;
  localparam int USBIS_SUM_BUFFER_NOT_READY_SUMMARY = 1;
  localparam int USBIS_SUM_EMPTY = 2;
  localparam int USBIS_SUM_KINDS = 3;
  localparam int USBIS_PIPES = 10;

  // Bits of the status word that software may clear by writing zero
  localparam logic [15:0] USBIS_CLEARABLE = 16'hF808;
  // Bits of the status word that may raise the interrupt
  localparam logic [15:0] USBIS_IRQ_SRC = 16'hFF08;

  // Control register bits
  localparam int USBIS_CTRL_PERI_BIT = 0;
  localparam int USBIS_CTRL_ACT0_BIT = 1;
  localparam int USBIS_CTRL_ACT1_BIT = 2;
  localparam int USBIS_CTRL_SYSTEM_CLOCK_ENABLE_BIT = 3;
  localparam logic [3:0] USBIS_CTRL_RESET = 4'h0;
  localparam logic [15:0] USBIS_MASK_RESET = 16'h0000;
  localparam logic [2:0] USBIS_FIELD_RESET = 3'h0;

  // Frame timing
  localparam int USBIS_FRAME_US = 1000;
  localparam int USBIS_CLK_MHZ = 10;
  localparam int USBIS_FRAME_CYCLES = USBIS_FRAME_US * USBIS_CLK_MHZ;
  localparam int USBIS_FCNT_W = 16;

  // Frame timer states
  typedef enum logic [1:0] {
    USBIS_FS_IDLE = 2'b01,
    USBIS_FS_RUN = 2'b10
  } usbis_fstate_t;

endpackage : usbis_pkg

// [usbis_edge_if.sv]
/*
  Carrier for one synchronised pin: its level and its edge pulses.
  Assumes source and sink share the system clock.
*/
`timescale 1ns/10ps
interface usbis_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : usbis_edge_if

// [usbis_pin_sync.sv]
/*
  Two-flop synchroniser with edge detection for one asynchronous pin.
  Assumes the pin may change at any time; edges are reported only once the
  pipeline holds real pin samples after reset.
*/
`timescale 1ns/10ps
module usbis_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and result
  input wire logic pin,
  usbis_edge_if.src edge_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic [2:0] fill_r;

  // Synchroniser chain and fill marker
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      fill_r <= 3'h0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  // Edges only after the chain is primed, so reset never fakes one
  assign edge_o.level = sync_r;
  assign edge_o.rise = fill_r[2] & sync_r & ~prev_r;
  assign edge_o.fall = fill_r[2] & ~sync_r & prev_r;

endmodule : usbis_pin_sync

// [usbis_bus_model.sv]
/*
  Far-side bus model: bus power, the D+ line and frame start tokens.
  Assumes the bench calls its tasks from the system clock domain.
*/
`timescale 1ns/10ps
module usbis_bus_model (
  // Clock
  input wire logic clk,
  // Bus lines
  output logic vbus_pin,
  output logic dp_pin,
  output logic sof_rx
);
  // Idle bus: no power, D+ at idle high level
  initial begin
    vbus_pin = 1'b0;
    dp_pin = 1'b1;
    sof_rx = 1'b0;
  end

  // Switch bus power on or off
  task automatic set_power(input logic on);
    @(posedge clk) vbus_pin <= on;
  endtask : set_power

  // Resume signalling pulls D+ low for a while
  task automatic do_resume();
    @(posedge clk) dp_pin <= 1'b0;
    repeat (8) @(posedge clk);
    dp_pin <= 1'b1;
  endtask : do_resume

  // One frame start token
  task automatic send_sof();
    @(posedge clk) sof_rx <= 1'b1;
    @(posedge clk) sof_rx <= 1'b0;
  endtask : send_sof
endmodule : usbis_bus_model

// [usb_interrupt_status_zero_tb.sv]
/*
  Self-checking bench for the interrupt status word zero block.
  Assumes the far-side model drives the USB pins; the bench plays software and engine.
*/
`timescale 1ns/10ps
module usb_interrupt_status_zero_tb;
  import usbis_pkg::*;
  localparam int FCYC = 20;
  typedef struct {logic [9:0] rs, re, ns, ne, es, ee; logic [2:0] sum;} usbis_row_t;
  logic clk, rst, wr, rd, setup_rx, irq;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, got;
  logic [2:0] dev_state_in, stage_in;
  logic [9:0] prs, pre, pns, pne, pes, pee;
  wire logic vbus_pin, dp_pin, sof_rx;
  int errors, checks_done;
  // Pipe status and enable rows with expected summary bits
  usbis_row_t rows [5] = '{
    '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 3'h0},
    '{10'h001, 10'h001, 10'h000, 10'h000, 10'h000, 10'h000, 3'h1},
    '{10'h002, 10'h001, 10'h000, 10'h000, 10'h000, 10'h000, 3'h0},
    '{10'h000, 10'h000, 10'h3FF, 10'h200, 10'h000, 10'h000, 3'h2},
    '{10'h200, 10'h200, 10'h001, 10'h001, 10'h001, 10'h3FF, 3'h7}};

  usbis_status #(.FRAME_CYCLES(FCYC)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .vbus_pin(vbus_pin), .dp_pin(dp_pin), .sof_rx(sof_rx), .setup_rx(setup_rx),
    .dev_state_in(dev_state_in), .stage_in(stage_in), .pipe_ready_status(prs), .pipe_ready_enable(pre),
    .pipe_not_ready_status(pns), .pipe_not_ready_enable(pne), .pipe_empty_status(pes),
    .pipe_empty_enable(pee), .irq(irq));
  usbis_bus_model bus (.clk(clk), .vbus_pin(vbus_pin), .dp_pin(dp_pin), .sof_rx(sof_rx));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] act);
    checks_done++;
    if (act !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, act);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    chk(nm, e, got & m);
  endtask : rd_chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // Read status until a flag shows, bounded
  task automatic poll_bit(input int b, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      rd_chk("poll", USBIS_STATUS_OFF, 16'h0, 16'h0);
      if (got[b] === 1'b1) break;
    end
    if (i == lim) begin
      errors++;
      $display("[ERR] flag %0d expected 1 seen 0", b);
      report_and_stop();
    end
  endtask : poll_bit

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watchdog
  initial begin
    wait_clk(20000);
    errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {wr, rd, setup_rx} = 3'h0;
    {addr, wdata, dev_state_in, stage_in} = '0;
    {prs, pre, pns, pne, pes, pee} = '0;
    errors = 0;
    checks_done = 0;
    wait_clk(8);
    rst <= 1'b0;
    wait_clk(3);
    rd_chk("status", USBIS_STATUS_OFF, 16'hFFFF, 16'h0000);
    rd_chk("mask", USBIS_MASK_OFF, 16'hFFFF, USBIS_MASK_RESET);
    rd_chk("ctrl", USBIS_CTRL_OFF, 16'hFFFF, 16'h0000);
    chk("irq", 16'h0, {15'h0, irq});
    foreach (rows[i]) begin
      @(posedge clk);
      {prs, pre, pns, pne, pes, pee} <= {rows[i].rs, rows[i].re, rows[i].ns, rows[i].ne, rows[i].es, rows[i].ee};
      wait_clk(2);
      rd_chk("summary", USBIS_STATUS_OFF, 16'h0700, {5'h0, rows[i].sum, 8'h00});
    end
    // Awkward cases: summaries read only, mask layout, irq
    wr_reg(USBIS_STATUS_OFF, 16'hF8FF);
    rd_chk("summary_ro", USBIS_STATUS_OFF, 16'h0700, 16'h0700);
    wr_reg(USBIS_MASK_OFF, 16'hFFFF);
    rd_chk("mask_rw", USBIS_MASK_OFF, 16'hFFFF, 16'hFF08);
    wr_reg(USBIS_MASK_OFF, 16'h0700);
    #1 chk("irq_sum", 16'h1, {15'h0, irq});
    @(posedge clk);
    {prs, pns, pes} <= '0;
    wait_clk(2);
    rd_chk("summary_drop", USBIS_STATUS_OFF, 16'h0700, 16'h0000);
    chk("irq_drop", 16'h0, {15'h0, irq});
    wr_reg(8'h50, 16'hFFFF);
    rd_chk("unmapped", 8'h50, 16'hFFFF, 16'h0000);
    // Bus power with system clock disabled
    wr_reg(USBIS_MASK_OFF, 16'h8000);
    bus.set_power(1'b1);
    wait_clk(5);
    rd_chk("vbus_rise", USBIS_STATUS_OFF, 16'h8080, 16'h8080);
    chk("irq_vbus", 16'h1, {15'h0, irq});
    for (int k = 0; k < 3; k++) rd_chk("level", USBIS_STATUS_OFF, 16'h0080, 16'h0080);
    wr_reg(USBIS_STATUS_OFF, 16'h7FFF);
    rd_chk("vbus_clr", USBIS_STATUS_OFF, 16'h8080, 16'h0080);
    chk("irq_clr", 16'h0, {15'h0, irq});
    bus.set_power(1'b0);
    wait_clk(5);
    rd_chk("vbus_fall", USBIS_STATUS_OFF, 16'h8080, 16'h8000);
    wr_reg(USBIS_STATUS_OFF, 16'h7FFF);
    // Peripheral role: states, stages, setup, resume
    wr_reg(USBIS_MASK_OFF, 16'h0000);
    wr_reg(USBIS_CTRL_OFF, 16'h0009);
    for (int s = 1; s < 5; s++) begin
      @(posedge clk);
      dev_state_in <= s[2:0];
      wait_clk(3);
      rd_chk("state", USBIS_STATUS_OFF, 16'h1070, {3'h0, 1'b1, 5'h0, s[2:0], 4'h0});
      wr_reg(USBIS_STATUS_OFF, 16'hEFFF);
    end
    for (int s = 1; s < 8; s++) begin
      @(posedge clk);
      stage_in <= s[2:0];
      wait_clk(3);
      rd_chk("stage", USBIS_STATUS_OFF, 16'h0807, {4'h0, 1'b1, 8'h00, s[2:0]});
      wr_reg(USBIS_STATUS_OFF, 16'hF7FF);
    end
    @(posedge clk);
    setup_rx <= 1'b1;
    @(posedge clk);
    setup_rx <= 1'b0;
    wait_clk(2);
    rd_chk("setup", USBIS_STATUS_OFF, 16'h0008, 16'h0008);
    wr_reg(USBIS_STATUS_OFF, 16'hFFFF);
    rd_chk("setup_w1", USBIS_STATUS_OFF, 16'h0008, 16'h0008);
    wr_reg(USBIS_STATUS_OFF, 16'hFFF7);
    rd_chk("setup_w0", USBIS_STATUS_OFF, 16'h0008, 16'h0000);
    bus.do_resume();
    wait_clk(3);
    rd_chk("resume", USBIS_STATUS_OFF, 16'h4000, 16'h4000);
    wr_reg(USBIS_STATUS_OFF, 16'hBFFF);
    // Resume still caught with the system clock stopped
    wr_reg(USBIS_CTRL_OFF, 16'h0001);
    bus.do_resume();
    wait_clk(3);
    rd_chk("resume_noclk", USBIS_STATUS_OFF, 16'h4000, 16'h4000);
    wr_reg(USBIS_STATUS_OFF, 16'hBFFF);
    // Host role: peripheral-only flags frozen
    wr_reg(USBIS_CTRL_OFF, 16'h0008);
    wr_reg(USBIS_MASK_OFF, 16'h8700);
    @(posedge clk);
    {dev_state_in, stage_in} <= 6'h08;
    bus.do_resume();
    wait_clk(3);
    rd_chk("host_frozen", USBIS_STATUS_OFF, 16'h5800, 16'h0000);
    wait_clk(3 * FCYC);
    rd_chk("frame_noport", USBIS_STATUS_OFF, 16'h2000, 16'h0000);
    wr_reg(USBIS_CTRL_OFF, 16'h000A);
    poll_bit(USBIS_FRAME_UPDATE_FLAG_BIT, FCYC);
    wr_reg(USBIS_CTRL_OFF, 16'h000C);
    wr_reg(USBIS_STATUS_OFF, 16'hDFFF);
    poll_bit(USBIS_FRAME_UPDATE_FLAG_BIT, FCYC);
    // Peripheral frames, then interpolation
    wr_reg(USBIS_CTRL_OFF, 16'h0009);
    wr_reg(USBIS_STATUS_OFF, 16'hDFFF);
    bus.send_sof();
    wait_clk(1);
    rd_chk("frame_sof", USBIS_STATUS_OFF, 16'h2000, 16'h2000);
    wr_reg(USBIS_STATUS_OFF, 16'hDFFF);
    poll_bit(USBIS_FRAME_UPDATE_FLAG_BIT, FCYC);
    report_and_stop();
  end
endmodule : usb_interrupt_status_zero_tb
